/* src/dci_pkg.sv */
// Constants and types shared by the drive control-input logic.
// Assumes a 100 MHz core clock; debounce is derived from it here, ramp tick and gate are given in cycles.
package dci_pkg;
   localparam int unsigned CLK_MHZ          = 100;
   // Contact debounce time in microseconds
   localparam int unsigned DEBOUNCE_US      = 5000;
   localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
   // Speed / setpoint word width
   localparam int unsigned SPD_W            = 16;
   // Ramp step interval in cycles
   localparam int unsigned RAMP_TICK_CYC    = 100;
   // Pulse measurement gate in cycles
   localparam int unsigned GATE_CYC         = 100000;
   // Reset values
   localparam logic [15:0] SPEED_RST        = 16'h0000;
   // Lockout mask bit positions, one per setpoint parameter
   localparam int unsigned MASK_SP1         = 0;
   localparam int unsigned MASK_SP2         = 1;
   localparam int unsigned MASK_SP3         = 2;
   localparam int unsigned MASK_SP4         = 3;
   // Number of contact inputs
   localparam int unsigned N_CONTACT        = 10;
   localparam int unsigned IN_RUN           = 0;
   localparam int unsigned IN_RSTOP         = 1;
   localparam int unsigned IN_FSTOP         = 2;
   localparam int unsigned IN_JOG           = 3;
   localparam int unsigned IN_LOOP          = 4;
   localparam int unsigned IN_PRISEC        = 5;
   localparam int unsigned IN_PSEL          = 6;
   localparam int unsigned IN_SSEL          = 7;
   localparam int unsigned IN_RAMPDIS       = 8;
   localparam int unsigned IN_LOCK          = 9;

   typedef enum logic [1:0] {
      DCI_IDLE,
      DCI_RUN,
      DCI_RSTOP,
      DCI_FSTOP
   } dci_state_t;
endpackage

/* src/dci_top.sv */
// Control-input logic of a DC speed drive: contact inputs, run state,
// setpoint choice, ramp, loop law, pulse speed measure, keypad lockout.
// Assumes raw contacts are asynchronous, closed = 1; one core clock.
// Function
// - Momentary run closure latches run state.
// - Ramped-stop opening latches stop, decelerates at programmed rate.
// - Fast-stop opening latches stop, zeroes speed at once.
// - Jog drives jog speed only while held; never latched.
// - Closed loop drives error, setpoint minus feedback, toward zero.
// - Open loop uses setpoint only, ignores feedback.
// - Primary/secondary input picks scaling format: master or follower.
// - Primary mode: setpoint 1 when select open, 2 when closed.
// - Secondary mode: setpoint 3 when select open, 4 when closed.
// - Ramp disable freezes ramps; ramping resumes on release.
// - Fast stop overrides ramp disable.
// - Lockout rejects keypad writes to masked setpoints.
// - Monitoring stays active during lockout.
// - Follower: reference frequency times ratio gives commanded speed.
// - Speed measured from feedback pulses, sensor type irrelevant.
// - Serial writes only with local/computer closed; monitoring always.
`timescale 1ns/1ns
`default_nettype none
module dci_top
   import dci_pkg::*;
#(
   parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
   parameter int unsigned GATE     = GATE_CYC
) (
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   input  wire logic [N_CONTACT-1:0] contact_in,
   input  wire logic                 local_computer_in,
   input  wire logic                 fb_pulse_in,
   input  wire logic                 ref_pulse_in,
   input  wire logic                 master_is_primary,
   input  wire logic [SPD_W-1:0]     accel_step,
   input  wire logic [SPD_W-1:0]     decel_step,
   input  wire logic [SPD_W-1:0]     jog_speed,
   input  wire logic [SPD_W-1:0]     gain_shift,
   input  wire logic [3:0]           lockout_mask_parameter,
   input  wire logic                 key_wr,
   input  wire logic                 ser_wr,
   input  wire logic [1:0]           par_idx,
   input  wire logic [SPD_W-1:0]     par_data,
   output logic                      running,
   output logic                      follower_active,
   output logic [1:0]                active_sp_idx,
   output logic [SPD_W-1:0]          ramped_ref,
   output logic [SPD_W-1:0]          drive_out,
   output logic [SPD_W-1:0]          measured_speed,
   output logic [SPD_W-1:0]          ref_freq,
   output logic                      write_rejected
);
   // Counts below two leave the debounce and gate counters with no terminal value
   if (DEB_CYC < 2 || GATE < 2) begin : g_bad_counts
      $error("dci_top: counts too small");
   end

   localparam int DW = $clog2(DEB_CYC + 1);
   localparam int GW = $clog2(GATE + 1);
   localparam int RW = $clog2(RAMP_TICK_CYC + 1);

   typedef struct packed {
      logic [N_CONTACT+2:0]       s1;
      logic [N_CONTACT+2:0]       s2;
      logic [N_CONTACT+2:0]       fb_prev;
      logic [N_CONTACT-1:0]       deb;
      logic [N_CONTACT-1:0][DW-1:0] dcnt;
      dci_state_t                 st;
      logic [3:0][SPD_W-1:0]      sp;
      logic [SPD_W-1:0]           ramp;
      logic [RW-1:0]              rtick;
      logic [GW-1:0]              gcnt;
      logic [SPD_W-1:0]           fb_cnt;
      logic [SPD_W-1:0]           rf_cnt;
      logic [SPD_W-1:0]           meas;
      logic [SPD_W-1:0]           rfreq;
      logic [SPD_W-1:0]           dout;
      logic                       run_o;
      logic                       fol_o;
      logic [1:0]                 sp_idx;
      logic                       rej;
   } dci_regs_t;

   dci_regs_t r_reg, r_next;

   // Saturating add/subtract of unsigned speed words
   function automatic logic [SPD_W-1:0] sat_step(input logic [SPD_W-1:0] cur,
                                                 input logic [SPD_W-1:0] tgt,
                                                 input logic [SPD_W-1:0] step);
      logic [SPD_W:0] t;
      t = '0;
      if (cur < tgt) begin
         t = {1'b0, cur} + {1'b0, step};
         sat_step = (t > {1'b0, tgt}) ? tgt : t[SPD_W-1:0];
      end else begin
         sat_step = (cur - tgt > step) ? SPD_W'(cur - step) : tgt;
      end
   endfunction

   logic [N_CONTACT-1:0] c;
   logic                 want_run;
   logic [SPD_W-1:0]     setpoint;
   logic [SPD_W-1:0]     target;
   logic [2*SPD_W-1:0]   prod;
   logic                 lc;

   always_comb begin
      r_next = r_reg;
      c  = r_reg.deb;
      lc = r_reg.s2[N_CONTACT];
      // Two-stage synchroniser; only stage two is read
      r_next.s1 = {ref_pulse_in, fb_pulse_in, local_computer_in, contact_in};
      r_next.s2 = r_reg.s1;
      r_next.fb_prev = r_reg.s2;
      // Counter debounce: input must hold steady the full window
      for (int i = 0; i < N_CONTACT; i++) begin
         if (r_reg.s2[i] == r_reg.deb[i]) begin
            r_next.dcnt[i] = '0;
         end else if (r_reg.dcnt[i] == DW'(DEB_CYC - 1)) begin
            r_next.deb[i]  = r_reg.s2[i];
            r_next.dcnt[i] = '0;
         end else begin
            r_next.dcnt[i] = r_reg.dcnt[i] + 1'b1;
         end
      end
      // Run/stop state; fast stop beats ramped stop beats run
      case (r_reg.st)
         DCI_IDLE: begin
            if (!c[IN_FSTOP]) r_next.st = DCI_FSTOP;
            else if (!c[IN_RSTOP]) r_next.st = DCI_IDLE;
            else if (c[IN_RUN]) r_next.st = DCI_RUN;
         end
         DCI_RUN: begin
            if (!c[IN_FSTOP]) r_next.st = DCI_FSTOP;
            else if (!c[IN_RSTOP]) r_next.st = DCI_RSTOP;
         end
         DCI_RSTOP: begin
            if (!c[IN_FSTOP]) r_next.st = DCI_FSTOP;
            else if (r_reg.ramp == '0) r_next.st = DCI_IDLE;
         end
         DCI_FSTOP: begin
            r_next.st = DCI_IDLE;
         end
         default: r_next.st = DCI_IDLE;
      endcase
      // Jog only while held and no stop is open
      want_run = (r_reg.st == DCI_RUN);
      // Setpoint choice by mode and select inputs
      r_next.fol_o  = c[IN_PRISEC] ? master_is_primary : !master_is_primary;
      r_next.sp_idx = c[IN_PRISEC] ? {1'b1, c[IN_SSEL]} : {1'b0, c[IN_PSEL]};
      setpoint = r_reg.sp[r_reg.sp_idx];
      // Follower: reference frequency times ratio, ratio in 8.8 fixed point
      prod = r_reg.rfreq * setpoint;
      if (r_reg.fol_o) begin
         target = prod[SPD_W+7:8];
      end else begin
         target = setpoint;
      end
      if (c[IN_JOG] && r_reg.st == DCI_IDLE && c[IN_FSTOP] && c[IN_RSTOP]) begin
         target = jog_speed;
      end else if (!want_run) begin
         target = '0;
      end
      // Ramp tick divider
      r_next.rtick = (r_reg.rtick == '0) ? RW'(RAMP_TICK_CYC - 1) : r_reg.rtick - 1'b1;
      if (r_reg.st == DCI_FSTOP || (r_next.st == DCI_FSTOP)) begin
         r_next.ramp = '0;
      end else if (r_reg.rtick == '0 && !c[IN_RAMPDIS]) begin
         r_next.ramp = sat_step(r_reg.ramp, target,
                                (target > r_reg.ramp) ? accel_step : decel_step);
      end
      // Loop law; trim acts on ramped reference minus measured speed
      if (r_reg.ramp == '0) begin
         r_next.dout = '0;
      end else if (c[IN_LOOP]) begin
         // Proportional trim on top of feed-forward
         if (r_reg.ramp >= r_reg.meas)
            r_next.dout = sat_step(r_reg.ramp, '1, (r_reg.ramp - r_reg.meas) >> gain_shift);
         else
            r_next.dout = sat_step(r_reg.ramp, '0, (r_reg.meas - r_reg.ramp) >> gain_shift);
      end else begin
         r_next.dout = r_reg.ramp;
      end
      // Pulse counting over a fixed gate, any sensor type alike
      r_next.gcnt = r_reg.gcnt + 1'b1;
      if (r_reg.s2[N_CONTACT+1] && !r_reg.fb_prev[N_CONTACT+1])
         r_next.fb_cnt = r_reg.fb_cnt + 1'b1;
      if (r_reg.s2[N_CONTACT+2] && !r_reg.fb_prev[N_CONTACT+2])
         r_next.rf_cnt = r_reg.rf_cnt + 1'b1;
      if (r_reg.gcnt == GW'(GATE - 1)) begin
         r_next.gcnt   = '0;
         r_next.meas   = r_next.fb_cnt;
         r_next.rfreq  = r_next.rf_cnt;
         r_next.fb_cnt = '0;
         r_next.rf_cnt = '0;
      end
      // Parameter writes: keypad gated by lockout mask, serial by local/computer
      r_next.rej = 1'b0;
      if (key_wr) begin
         if (c[IN_LOCK] && lockout_mask_parameter[par_idx]) r_next.rej = 1'b1;
         else r_next.sp[par_idx] = par_data;
      end else if (ser_wr) begin
         if (!lc) r_next.rej = 1'b1;
         else r_next.sp[par_idx] = par_data;
      end
      r_next.run_o = (r_next.st == DCI_RUN);
   end

   // Single state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // Monitoring outputs stay live whatever the lockout state
   assign running         = r_reg.run_o;
   assign follower_active = r_reg.fol_o;
   assign active_sp_idx   = r_reg.sp_idx;
   assign ramped_ref      = r_reg.ramp;
   assign drive_out       = r_reg.dout;
   assign measured_speed  = r_reg.meas;
   assign ref_freq        = r_reg.rfreq;
   assign write_rejected  = r_reg.rej;

   a_fstop_zeroes_ramp: assert property (@(posedge core_clk) disable iff (!nrst)
      r_reg.st == DCI_FSTOP |-> r_reg.ramp == '0)
      else $error("fast stop left ramp nonzero");
   a_fstop_beats_rampdis: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.st == DCI_RUN && !r_reg.deb[IN_FSTOP]) |=> r_reg.ramp == '0)
      else $error("fast stop did not zero ramp");
   a_run_latches: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.st == DCI_IDLE && r_reg.deb[IN_RUN] && r_reg.deb[IN_FSTOP] && r_reg.deb[IN_RSTOP])
      |=> r_reg.st == DCI_RUN)
      else $error("run closure not latched");
   a_rstop_latches: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.st == DCI_RUN && r_reg.deb[IN_FSTOP] && !r_reg.deb[IN_RSTOP]) |=> r_reg.st == DCI_RSTOP)
      else $error("ramped stop not latched");
   a_rampdis_freezes: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.deb[IN_RAMPDIS] && r_reg.st != DCI_FSTOP && r_next.st != DCI_FSTOP)
      |=> $stable(r_reg.ramp))
      else $error("ramp moved while disabled");
   a_open_loop_ff: assert property (@(posedge core_clk) disable iff (!nrst)
      (!r_reg.deb[IN_LOOP] && r_reg.ramp != '0) |=> r_reg.dout == $past(r_reg.ramp))
      else $error("open loop output not setpoint-only");
   a_lockout_rejects: assert property (@(posedge core_clk) disable iff (!nrst)
      (key_wr && r_reg.deb[IN_LOCK] && lockout_mask_parameter[par_idx]) |=> write_rejected && $stable(r_reg.sp))
      else $error("locked keypad write accepted");
   a_serial_gate: assert property (@(posedge core_clk) disable iff (!nrst)
      (ser_wr && !key_wr && !r_reg.s2[N_CONTACT]) |=> write_rejected && $stable(r_reg.sp))
      else $error("serial write accepted in local");
   a_sp_select: assert property (@(posedge core_clk) disable iff (!nrst)
      (!r_reg.deb[IN_PRISEC]) |=> active_sp_idx == {1'b0, $past(r_reg.deb[IN_PSEL])})
      else $error("primary setpoint select wrong");
   a_sec_select: assert property (@(posedge core_clk) disable iff (!nrst)
      r_reg.deb[IN_PRISEC] |=> active_sp_idx == {1'b1, $past(r_reg.deb[IN_SSEL])})
      else $error("secondary setpoint select wrong");
   a_format_pick: assert property (@(posedge core_clk) disable iff (!nrst)
      1'b1 |=> follower_active == ($past(r_reg.deb[IN_PRISEC]) == $past(master_is_primary)))
      else $error("scaling format wrong");

   // Fast stop is two steps: stop state with zero ramp, then idle with ramp still zero
   sequence s_fstop_entered;
      r_reg.st == DCI_FSTOP && r_reg.ramp == '0;
   endsequence
   sequence s_back_idle;
      r_reg.st == DCI_IDLE && r_reg.ramp == '0;
   endsequence
   a_fstop_sequence: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.st == DCI_RUN && !r_reg.deb[IN_FSTOP]) |=> s_fstop_entered ##1 s_back_idle)
      else $error("fast stop sequence broken");

   // Priority: an open fast stop always wins, an open ramped stop blocks run
   a_fstop_first: assert property (@(posedge core_clk) disable iff (!nrst)
      (!r_reg.deb[IN_FSTOP] && r_reg.st != DCI_FSTOP) |=> r_reg.st == DCI_FSTOP)
      else $error("fast stop not taken first");
   a_rstop_beats_run: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.st == DCI_IDLE && r_reg.deb[IN_FSTOP] && !r_reg.deb[IN_RSTOP]) |=> r_reg.st == DCI_IDLE)
      else $error("run taken with ramped stop open");
   a_rstop_no_rise: assert property (@(posedge core_clk) disable iff (!nrst)
      r_reg.st == DCI_RSTOP |=> r_reg.ramp <= $past(r_reg.ramp))
      else $error("ramp rose during ramped stop");
   a_rstop_done: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.st == DCI_RSTOP && r_reg.deb[IN_FSTOP] && r_reg.ramp == '0) |=> r_reg.st == DCI_IDLE)
      else $error("ramped stop did not finish");

   // Jog never latches: without run the state stays out of RUN, and with jog released the ramp does not rise
   a_idle_no_run: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.st == DCI_IDLE && !r_reg.deb[IN_RUN]) |=> r_reg.st != DCI_RUN)
      else $error("run entered without run closure");
   a_idle_no_rise: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.st == DCI_IDLE && !r_reg.deb[IN_JOG]) |=> r_reg.ramp <= $past(r_reg.ramp))
      else $error("ramp rose with jog released");

   // Loop law outputs
   a_zero_ramp_out: assert property (@(posedge core_clk) disable iff (!nrst)
      r_reg.ramp == '0 |=> drive_out == '0)
      else $error("output nonzero at zero ramp");
   a_closed_up: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.deb[IN_LOOP] && r_reg.ramp != '0 && r_reg.ramp >= r_reg.meas) |=> drive_out >= $past(r_reg.ramp))
      else $error("closed loop trim has wrong sign");

   // Parameter writes that pass the gates land the next cycle
   a_accepted_write: assert property (@(posedge core_clk) disable iff (!nrst)
      (key_wr && !(r_reg.deb[IN_LOCK] && lockout_mask_parameter[par_idx]))
      |=> !write_rejected && r_reg.sp[$past(par_idx)] == $past(par_data))
      else $error("keypad write lost");
   a_serial_accept: assert property (@(posedge core_clk) disable iff (!nrst)
      (ser_wr && !key_wr && r_reg.s2[N_CONTACT]) |=> !write_rejected && r_reg.sp[$past(par_idx)] == $past(par_data))
      else $error("serial write lost");

   // Speed measure refreshes only at gate end, with the edges of the whole gate
   a_meas_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      r_reg.gcnt != GW'(GATE - 1) |=> $stable(measured_speed))
      else $error("speed measure moved inside gate");
   a_gate_count: assert property (@(posedge core_clk) disable iff (!nrst)
      (r_reg.gcnt == GW'(GATE - 1) && !(r_reg.s2[N_CONTACT+1] && !r_reg.fb_prev[N_CONTACT+1]))
      |=> measured_speed == $past(r_reg.fb_cnt))
      else $error("speed measure not gate count");
endmodule
`default_nettype wire

/* verif/dci_switch_model.sv */
// Operator side of the control terminals: contacts and sensor pulse trains.
// Assumes the bench commands contact levels after each rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module dci_switch_model
   import dci_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic [N_CONTACT-1:0] sw_cmd,
   input  wire logic                 allow_bad,
   input  wire logic [7:0]           fb_per,
   input  wire logic [7:0]           ref_per,
   output logic      [N_CONTACT-1:0] contact_in,
   output logic                      fb_pulse_in,
   output logic                      ref_pulse_in
);
   logic [7:0] fb_cnt = 8'h00;
   logic [7:0] ref_cnt = 8'h00;

   // Run is pressed only with both stops closed, unless misuse is commanded
   always_comb begin
      contact_in = sw_cmd;
      if (!allow_bad && !(sw_cmd[IN_RSTOP] && sw_cmd[IN_FSTOP])) begin
         contact_in[IN_RUN] = 1'b0;
      end
   end

   // Free-running trains; same waveform whatever the sensor type
   always @(posedge core_clk) begin
      fb_cnt <= (fb_cnt + 8'h01 >= fb_per) ? 8'h00 : fb_cnt + 8'h01;
      ref_cnt <= (ref_cnt + 8'h01 >= ref_per) ? 8'h00 : ref_cnt + 8'h01;
   end
   assign fb_pulse_in = fb_cnt < (fb_per >> 1);
   assign ref_pulse_in = ref_cnt < (ref_per >> 1);
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the drive control-input block.
// Assumes dci_top with short debounce and gate, and the switch model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import dci_pkg::*;
   logic                 core_clk, nrst, allow_bad, local_computer_in, master_is_primary;
   logic                 fb_pulse_in, ref_pulse_in, key_wr, ser_wr, running, follower_active, write_rejected;
   logic [N_CONTACT-1:0] sw_cmd, contact_in;
   logic [7:0]           fb_per, ref_per;
   logic [1:0]           par_idx, active_sp_idx, idx;
   logic [3:0]           lockout_mask_parameter;
   logic [SPD_W-1:0]     accel_step, decel_step, jog_speed, gain_shift, par_data;
   logic [SPD_W-1:0]     ramped_ref, drive_out, measured_speed, ref_freq, snap;
   int                   fails = 0;
   int                   checks = 0;
   int                   cyc = 0;

   dci_top #(.DEB_CYC(4), .GATE(50)) i_dci_top (.core_clk, .nrst, .contact_in, .local_computer_in,
      .fb_pulse_in, .ref_pulse_in, .master_is_primary, .accel_step, .decel_step, .jog_speed, .gain_shift,
      .lockout_mask_parameter, .key_wr, .ser_wr, .par_idx, .par_data, .running, .follower_active,
      .active_sp_idx, .ramped_ref, .drive_out, .measured_speed, .ref_freq, .write_rejected);
   dci_switch_model i_dci_switch_model (.core_clk, .sw_cmd, .allow_bad, .fb_per, .ref_per, .contact_in,
      .fb_pulse_in, .ref_pulse_in);

   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         $display("ERROR %0t timeout", $time);
         end_of_test();
      end
   end

   // Verdict
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cmp_word(input logic [SPD_W-1:0] got, input logic [SPD_W-1:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t word got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t flag got %b exp %b", $time, got, exp);
      end
   endtask

   // All stimulus lands 1 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Twelve cycles covers two sync stages, debounce and state update
   task automatic run_pulse();
      sw_cmd[IN_RUN] = 1'b1;
      tick(12);
      sw_cmd[IN_RUN] = 1'b0;
      tick(12);
   endtask

   // One-cycle write strobe; refusal flag is due the following cycle
   task automatic wr(input logic key, input logic [1:0] i, input logic [SPD_W-1:0] d, input logic rej);
      key_wr = key;
      ser_wr = !key;
      par_idx = i;
      par_data = d;
      tick(1);
      cmp_flag(write_rejected, rej);
      // Strobes drop for a cycle, so back-to-back calls never reassign them in one step
      key_wr = 1'b0;
      ser_wr = 1'b0;
      tick(1);
   endtask

   // Ramp moves once per 100 cycles, so waits are bounded polls
   task automatic wait_ref(input logic [SPD_W-1:0] e, input int lim);
      for (int i = 0; i < lim && ramped_ref !== e; i++) tick(1);
      cmp_word(ramped_ref, e);
   endtask

   function automatic logic [1:0] exp_sp(input logic [2:0] s);
      return s[0] ? (s[2] ? 2'd3 : 2'd2) : (s[1] ? 2'd1 : 2'd0);
   endfunction

   function automatic logic [SPD_W-1:0] exp_closed(input logic [SPD_W-1:0] r, m, g);
      logic [SPD_W:0] s;
      if (r >= m) s = {1'b0, r} + ((r - m) >> g);
      else s = {1'b0, r} - ((m - r) >> g);
      return s[SPD_W] ? ((r >= m) ? '1 : '0) : s[SPD_W-1:0];
   endfunction

   initial begin
      {nrst, key_wr, ser_wr, allow_bad, par_idx, par_data, sw_cmd, idx} = '0;
      {accel_step, decel_step, jog_speed, gain_shift} = {16'h0010, 16'h0010, 16'h0030, 16'h0001};
      {local_computer_in, master_is_primary, fb_per, ref_per, lockout_mask_parameter} = {2'b11, 8'h05, 8'h0a, 4'h0};
      void'($urandom(36));
      repeat (20) @(posedge core_clk);
      #1 nrst = 1'b1;
      cmp_flag(running, 1'b0);
      allow_bad = 1'b1;
      run_pulse();
      cmp_flag(running, 1'b0);
      allow_bad = 1'b0;
      $display("test refusal done");
      for (int i = 0; i < 8; i++) begin
         sw_cmd[7:5] = 3'(i);
         tick(12);
         cmp_word(SPD_W'(active_sp_idx), SPD_W'(exp_sp(3'(i))));
         cmp_flag(follower_active, i[0]);
      end
      master_is_primary = 1'b0;
      tick(3);
      cmp_flag(follower_active, 1'b0);
      master_is_primary = 1'b1;
      sw_cmd[7:5] = 3'b000;
      sw_cmd[IN_LOCK] = 1'b1;
      tick(12);
      $display("test select done");
      for (int i = 0; i < 8; i++) begin
         lockout_mask_parameter = 4'($urandom);
         idx = 2'($urandom);
         wr(1'b1, idx, 16'($urandom), lockout_mask_parameter[idx]);
      end
      cmp_word(measured_speed, 16'h000a);
      cmp_word(ref_freq, 16'h0005);
      sw_cmd[IN_LOCK] = 1'b0;
      local_computer_in = 1'b0;
      tick(12);
      wr(1'b0, 2'd1, 16'h1234, 1'b1);
      local_computer_in = 1'b1;
      tick(4);
      wr(1'b0, 2'd0, 16'h0040, 1'b0);
      wr(1'b1, 2'd2, 16'h0200, 1'b0);
      $display("test writes done");
      sw_cmd[2:1] = 2'b11;
      tick(12);
      run_pulse();
      cmp_flag(running, 1'b1);
      wait_ref(16'h0040, 700);
      tick(1); // Output register trails the ramp by one cycle
      cmp_word(drive_out, 16'h0040);
      sw_cmd[IN_LOOP] = 1'b1;
      tick(12);
      cmp_word(drive_out, exp_closed(16'h0040, 16'h000a, 16'h0001));
      sw_cmd[IN_LOOP] = 1'b0;
      wr(1'b1, 2'd0, 16'h0080, 1'b0);
      sw_cmd[IN_RAMPDIS] = 1'b1;
      tick(12);
      snap = ramped_ref;
      tick(300);
      cmp_word(ramped_ref, snap);
      sw_cmd[IN_RAMPDIS] = 1'b0;
      wait_ref(16'h0080, 1000);
      sw_cmd[IN_RAMPDIS] = 1'b1;
      decel_step = 16'h0001;
      tick(12);
      sw_cmd[IN_FSTOP] = 1'b0;
      tick(12);
      cmp_word(ramped_ref, 16'h0000);
      cmp_flag(running, 1'b0);
      sw_cmd[IN_RAMPDIS] = 1'b0;
      sw_cmd[IN_FSTOP] = 1'b1;
      decel_step = 16'h0010;
      tick(12);
      $display("test fast stop done");
      run_pulse();
      wait_ref(16'h0080, 1000);
      sw_cmd[IN_RSTOP] = 1'b0;
      tick(12);
      cmp_flag(running, 1'b0);
      cmp_flag(ramped_ref > 16'h006f, 1'b1);
      wait_ref(16'h0000, 1000);
      sw_cmd[IN_RSTOP] = 1'b1;
      tick(12);
      $display("test ramped stop done");
      sw_cmd[IN_JOG] = 1'b1;
      wait_ref(16'h0030, 600);
      sw_cmd[IN_JOG] = 1'b0;
      wait_ref(16'h0000, 600);
      cmp_flag(running, 1'b0);
      $display("test jog done");
      sw_cmd[IN_PRISEC] = 1'b1;
      tick(12);
      run_pulse();
      wait_ref(16'h000a, 400);
      $display("test follower done");
      end_of_test();
   end
endmodule
`default_nettype wire
